// file: serial_ctl_pkg.sv
package serial_ctl_pkg;
    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int          FRAME_BITS  = 16;
    localparam int          ADDR_W      = 7;
    localparam int          DATA_W      = 8;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  CNT_LAST    = 5'h0F;
    localparam logic [4:0]  CNT_DONE    = 5'h10;
    localparam logic [4:0]  CNT_DATA    = 5'h08;
    localparam logic        RW_READ     = 1'b1;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int          NUM_REGS      = 32;
    localparam logic [6:0]  ADDR_INT_EN   = 7'h00;
    localparam logic [6:0]  ADDR_INT_STAT = 7'h01;
    localparam logic [6:0]  ADDR_CMD_LO   = 7'h02;
    localparam logic [6:0]  ADDR_CMD_HI   = 7'h1F;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0]  INT_EN_RST    = 8'h00;
    localparam logic [7:0]  INT_STAT_RST  = 8'h00;
    localparam logic [7:0]  CMD_RST       = 8'h00;
    localparam logic [7:0]  RDBUF_RST     = 8'h00;

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_READ = 2'b10
    } acc_state_t;

    function automatic logic is_cmd(input logic [6:0] a);
        is_cmd = (a >= ADDR_CMD_LO) && (a <= ADDR_CMD_HI);
    endfunction : is_cmd
endpackage : serial_ctl_pkg

// file: sync2.sv
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s1_d;

    always_comb begin
        s1_d = d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= s1_d;
            q    <= s1_q;
        end
    end
endmodule : sync2

// file: cmd_regs.sv
module cmd_regs #(
    parameter int         DEPTH = 32,
    parameter int         W     = 8,
    parameter logic [7:0] RST   = 8'h00
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [W-1:0]             wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [W-1:0]             rdata_q
);
    logic [W-1:0] mem_q [DEPTH];

    // ----------------------------------------------------------------
    // storage, cleared to defaults on reset
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= RST[W-1:0];
            end
            rdata_q <= '0;
        end else begin
            if (we) begin
                mem_q[waddr] <= wdata;
            end
            rdata_q <= mem_q[raddr];
        end
    end
endmodule : cmd_regs

// file: serial_ctl.sv
module serial_ctl
    import serial_ctl_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       HOST_MODE,
    input  wire logic [7:0] EVENTS,
    input  wire logic       SCLK,
    input  wire logic       CS_N,
    input  wire logic       SERIAL_IN,
    output logic            SERIAL_OUT,
    output logic            SERIAL_OUT_OE,
    input  wire logic       INT_N_I,
    output logic            INT_N_O,
    output logic            INT_N_OE,
    output logic            RX_LOSS_MUTE
);
    import serial_ctl_pkg::*;

    // ----------------------------------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------------------------------
    logic       rst_n;
    logic       host_q;
    logic       pin_s;
    logic       req_s;
    logic       link_arst_n;

    sync2 #(.W(1)) u_rst (.clk(CLK), .rst_n(NRST), .d(1'b1), .q(rst_n));
    sync2 #(.W(1)) u_host (.clk(CLK), .rst_n(rst_n), .d(HOST_MODE), .q(host_q));
    sync2 #(.W(1)) u_pin (.clk(CLK), .rst_n(rst_n), .d(INT_N_I), .q(pin_s));

    assign link_arst_n = rst_n & ~CS_N;

    // ----------------------------------------------------------------
    // link side: frame shift on rising serial clock
    // ----------------------------------------------------------------
    logic [4:0]  cnt_q, cnt_d;
    logic [14:0] sh_q, sh_d;
    logic        rdf_q, rdf_d;

    always_comb begin
        cnt_d = cnt_q;
        sh_d  = sh_q;
        rdf_d = rdf_q;
        if (cnt_q < CNT_DONE) begin
            cnt_d = cnt_q + 5'h01;
            sh_d  = {sh_q[13:0], SERIAL_IN};
        end
        if (cnt_q == 5'h00) begin
            rdf_d = (SERIAL_IN == RW_READ);
        end
    end

    always_ff @(posedge SCLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            cnt_q <= '0;
            sh_q  <= '0;
            rdf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sh_q  <= sh_d;
            rdf_q <= rdf_d;
        end
    end

    // ----------------------------------------------------------------
    // link side: completed frame held for the core domain
    // ----------------------------------------------------------------
    logic       hrw_q, hrw_d;
    logic [6:0] haddr_q, haddr_d;
    logic [7:0] hdata_q, hdata_d;
    logic       req_tgl_q, req_tgl_d;

    always_comb begin
        hrw_d     = hrw_q;
        haddr_d   = haddr_q;
        hdata_d   = hdata_q;
        req_tgl_d = req_tgl_q;
        if (!CS_N && cnt_q == CNT_LAST) begin
            hrw_d     = sh_q[14];
            haddr_d   = sh_q[13:7];
            hdata_d   = {sh_q[6:0], SERIAL_IN};
            req_tgl_d = ~req_tgl_q;
        end
    end

    always_ff @(posedge SCLK or negedge rst_n) begin
        if (!rst_n) begin
            hrw_q     <= 1'b0;
            haddr_q   <= '0;
            hdata_q   <= '0;
            req_tgl_q <= 1'b0;
        end else begin
            hrw_q     <= hrw_d;
            haddr_q   <= haddr_d;
            hdata_q   <= hdata_d;
            req_tgl_q <= req_tgl_d;
        end
    end

    // ----------------------------------------------------------------
    // link side: read data on falling serial clock
    // ----------------------------------------------------------------
    logic [7:0] rdbuf_q, rdbuf_d;
    logic       out_q, out_d;
    logic       oe_q, oe_d;

    always_comb begin
        out_d = out_q;
        oe_d  = 1'b0;
        if (rdf_q && cnt_q >= CNT_DATA && cnt_q < CNT_DONE) begin
            out_d = rdbuf_q[~cnt_q[2:0]];
            oe_d  = 1'b1;
        end
    end

    always_ff @(negedge SCLK or negedge link_arst_n) begin
        if (!link_arst_n) begin
            out_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
        end
    end

    assign SERIAL_OUT    = out_q;
    assign SERIAL_OUT_OE = oe_q & ~CS_N & host_q;

    // ----------------------------------------------------------------
    // core side: access sequencer
    // ----------------------------------------------------------------
    sync2 #(.W(1)) u_req (.clk(CLK), .rst_n(rst_n), .d(req_tgl_q), .q(req_s));

    acc_state_t st_q, st_d;
    logic       seen_q, seen_d;
    logic [7:0] en_q, en_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] mem_rd;
    logic       req_go;
    logic       wr_go;
    logic       mem_we;

    assign req_go = (req_s ^ seen_q) && host_q && st_q == ST_IDLE;
    assign wr_go  = req_go && hrw_q != RW_READ;
    assign mem_we = wr_go && is_cmd(haddr_q);

    always_comb begin
        st_d    = st_q;
        seen_d  = seen_q;
        en_d    = en_q;
        rdbuf_d = rdbuf_q;
        stat_d  = stat_q | EVENTS;
        case (st_q)
            ST_IDLE: begin
                if (req_s ^ seen_q) begin
                    seen_d = req_s;
                end
                if (wr_go) begin
                    if (haddr_q == ADDR_INT_EN) begin
                        en_d = hdata_q;
                    end else if (haddr_q == ADDR_INT_STAT) begin
                        stat_d = (stat_q & ~hdata_q) | EVENTS;
                    end
                end else if (req_go) begin
                    if (haddr_q == ADDR_INT_EN) begin
                        rdbuf_d = en_q;
                    end else if (haddr_q == ADDR_INT_STAT) begin
                        rdbuf_d = stat_q;
                    end else if (is_cmd(haddr_q)) begin
                        st_d = ST_READ;
                    end else begin
                        rdbuf_d = 8'h00;
                    end
                end
            end
            ST_READ: begin
                rdbuf_d = mem_rd;
                st_d    = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q    <= ST_IDLE;
            seen_q  <= 1'b0;
            en_q    <= INT_EN_RST;
            stat_q  <= INT_STAT_RST;
            rdbuf_q <= RDBUF_RST;
        end else begin
            st_q    <= st_d;
            seen_q  <= seen_d;
            en_q    <= en_d;
            stat_q  <= stat_d;
            rdbuf_q <= rdbuf_d;
        end
    end

    cmd_regs #(.DEPTH(NUM_REGS), .W(DATA_W), .RST(CMD_RST)) u_regs (
        .clk     (CLK),
        .rst_n   (rst_n),
        .we      (mem_we),
        .waddr   (haddr_q[4:0]),
        .wdata   (hdata_q),
        .raddr   (haddr_q[4:0]),
        .rdata_q (mem_rd)
    );

    // ----------------------------------------------------------------
    // core side: shared interrupt / loss mute pin
    // ----------------------------------------------------------------
    logic irq_q, irq_d;
    logic mute_q, mute_d;

    always_comb begin
        irq_d  = host_q && |(stat_q & en_q);
        mute_d = !host_q && pin_s;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_q  <= 1'b0;
            mute_q <= 1'b0;
        end else begin
            irq_q  <= irq_d;
            mute_q <= mute_d;
        end
    end

    assign INT_N_O      = ~irq_q;
    assign INT_N_OE     = host_q;
    assign RX_LOSS_MUTE = mute_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_pin_role_host: assert property (@(posedge CLK) disable iff (!rst_n)
        host_q && $past(host_q) |-> INT_N_OE && !RX_LOSS_MUTE)
        else $error("interrupt pin not driven in host mode");
    a_irq_enabled: assert property (@(posedge CLK) disable iff (!rst_n)
        host_q && $past(host_q) && (stat_q & en_q) == 8'h00 ##1 host_q |-> INT_N_O)
        else $error("interrupt low without enabled event");
    a_irq_raised: assert property (@(posedge CLK) disable iff (!rst_n)
        host_q && (EVENTS & en_q) != 8'h00 ##1 host_q |-> ##1 !INT_N_O)
        else $error("enabled event did not raise interrupt");
    a_irq_held: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(INT_N_O) && $past(host_q, 2) && host_q |-> $past(wr_go, 2))
        else $error("interrupt released without service");
    a_hw_no_irq: assert property (@(posedge CLK) disable iff (!rst_n)
        !host_q |-> !INT_N_OE ##1 ($past(host_q) || INT_N_O))
        else $error("interrupt signalled in hardware mode");
    a_mute_follow: assert property (@(posedge CLK) disable iff (!rst_n)
        !host_q && pin_s ##1 !host_q |-> RX_LOSS_MUTE)
        else $error("loss mute not following pin");
    a_reset_values: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(rst_n) |-> en_q == INT_EN_RST && stat_q == INT_STAT_RST && irq_q == 1'b0)
        else $error("registers not at defaults after reset");
    a_frame_end: assert property (@(negedge SCLK) disable iff (!link_arst_n)
        $past(cnt_q) == CNT_LAST && cnt_q > CNT_LAST |-> cnt_q == CNT_DONE
            && req_tgl_q != $past(req_tgl_q))
        else $error("frame not taken on sixteenth rising edge");
    a_out_release: assert property (@(posedge SCLK) disable iff (!link_arst_n)
        cnt_q < CNT_DATA || cnt_q == CNT_DONE |-> !SERIAL_OUT_OE)
        else $error("serial output driven outside read data");
    a_reset_release: assert property (@(posedge CLK) disable iff (!NRST)
        rst_n |-> $past(NRST, 1) && $past(NRST, 2))
        else $error("reset released without two clock edges");
    a_stat_sticky: assert property (@(posedge CLK) disable iff (!rst_n)
        (stat_q & en_q) != 8'h00 && !wr_go |=> (stat_q & en_q) != 8'h00)
        else $error("pending interrupt dropped without service");
    a_unmapped_zero: assert property (@(posedge CLK) disable iff (!rst_n)
        req_go && hrw_q == RW_READ && haddr_q > ADDR_CMD_HI |=> rdbuf_q == 8'h00)
        else $error("unmapped read did not return zero");

    c_read_frame: cover property (@(posedge CLK) disable iff (!rst_n)
        st_q == ST_READ);
    c_write_frame: cover property (@(posedge CLK) disable iff (!rst_n)
        mem_we);
    c_irq_low: cover property (@(posedge CLK) disable iff (!rst_n)
        $fell(INT_N_O));
    c_hw_mute: cover property (@(posedge CLK) disable iff (!rst_n)
        $rose(RX_LOSS_MUTE));
    c_irq_service: cover property (@(posedge CLK) disable iff (!rst_n)
        $rose(INT_N_O));
endmodule : serial_ctl

// file: host_model.sv
module host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_q;
    wire logic pin;
    // ----------------------------------------------------------------
    // released line shows the inverse of its last value
    // ----------------------------------------------------------------
    assign pin = serial_oe ? serial_out : ~last_q;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
        last_q = 1'b0;
    end
    // ----------------------------------------------------------------
    // one frame, clock stands still outside it
    // ----------------------------------------------------------------
    task automatic frame(input logic [15:0] word, input int nclk,
                         output logic [7:0] rd, output logic [7:0] oe);
        rd = 8'h00;
        oe = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            serial_in = word[15-i];
            #16;
            sclk = 1'b1;
            if (i >= 8) begin
                rd = {rd[6:0], pin};
                oe = {oe[6:0], serial_oe};
                last_q = pin;
            end
            #16;
            sclk = 1'b0;
        end
        #8;
        cs_n = 1'b1;
        serial_in = ~serial_in;
    endtask : frame
endmodule : host_model

// file: tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import serial_ctl_pkg::*;
    logic       CLK, NRST, HOST_MODE, mute_drv;
    logic [7:0] EVENTS, rd, oe, d;
    logic [6:0] a;
    wire logic  SCLK, CS_N, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE;
    wire logic  INT_N_O, INT_N_OE, RX_LOSS_MUTE, int_pin;
    int         mismatches, checks, seed;
    logic [7:0] mreg [NUM_REGS];
    // ----------------------------------------------------------------
    // design, host and shared pin
    // ----------------------------------------------------------------
    assign int_pin = INT_N_OE ? INT_N_O : mute_drv;
    serial_ctl uut (.CLK(CLK), .NRST(NRST), .HOST_MODE(HOST_MODE), .EVENTS(EVENTS),
        .SCLK(SCLK), .CS_N(CS_N), .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
        .SERIAL_OUT_OE(SERIAL_OUT_OE), .INT_N_I(int_pin), .INT_N_O(INT_N_O),
        .INT_N_OE(INT_N_OE), .RX_LOSS_MUTE(RX_LOSS_MUTE));
    host_model host (.sclk(SCLK), .cs_n(CS_N), .serial_in(SERIAL_IN),
        .serial_out(SERIAL_OUT), .serial_oe(SERIAL_OUT_OE));
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask : tick
    task automatic wr(input logic [6:0] wa, input logic [7:0] wd, input int nclk,
                      input bit take);
        host.frame({1'b0, wa, wd}, nclk, rd, oe);
        if (take && wa < NUM_REGS) begin
            if (wa == ADDR_INT_STAT) begin
                mreg[1] &= ~wd;
            end else begin
                mreg[wa] = wd;
            end
        end
        tick(12);
    endtask : wr
    task automatic rdc(input logic [6:0] ra);
        logic [7:0] e;
        e = (ra < NUM_REGS) ? mreg[ra] : 8'h00;
        repeat (2) begin
            host.frame({RW_READ, ra, 8'h00}, 16, rd, oe);
            tick(12);
        end
        chk(rd, e);
        chk(oe, 8'hFF);
        chk1(SERIAL_OUT_OE, 1'b0);
    endtask : rdc
    task automatic ev(input logic [7:0] v);
        EVENTS = v;
        tick(1);
        EVENTS = 8'h00;
        mreg[1] |= v;
    endtask : ev
    task automatic mres();
        foreach (mreg[i]) mreg[i] = 8'h00;
    endtask : mres
    initial begin
        #500000;
        mismatches++;
        close_out();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        NRST = 1'b0;
        HOST_MODE = 1'b1;
        EVENTS = 8'h00;
        mute_drv = 1'b0;
        mismatches = 0;
        checks = 0;
        mres();
        seed = $urandom(32'h4D13);
        repeat (8) @(posedge CLK);
        #2;
        NRST = 1'b1;
        tick(10);
        chk1(INT_N_OE, 1'b1);
        chk1(INT_N_O, 1'b1);
        for (int i = 0; i < 4; i++) rdc(7'($urandom_range(31, 0)));
        $display("test 1 done");
        for (int i = 0; i < 6; i++) begin
            a = 7'($urandom_range(31, 2));
            d = 8'($urandom);
            wr(a, d, 16, 1);
            rdc(a);
        end
        wr(a, ~mreg[a], 15, 0);
        rdc(a);
        wr(7'h7F, 8'h5A, 16, 1);
        rdc(7'h7F);
        $display("test 2 done");
        wr(ADDR_INT_EN, 8'h04, 16, 1);
        ev(8'h08);
        tick(6);
        chk1(INT_N_O, 1'b1);
        rdc(ADDR_INT_STAT);
        ev(8'h04);
        tick(2);
        chk1(INT_N_O, 1'b0);
        tick(20);
        chk1(INT_N_O, 1'b0);
        wr(ADDR_INT_STAT, 8'h04, 16, 1);
        chk1(INT_N_O, 1'b1);
        ev(8'h04);
        tick(3);
        chk1(INT_N_O, 1'b0);
        wr(ADDR_INT_EN, 8'h00, 16, 1);
        chk1(INT_N_O, 1'b1);
        wr(ADDR_INT_STAT, 8'hFF, 16, 1);
        rdc(ADDR_INT_STAT);
        $display("test 3 done");
        HOST_MODE = 1'b0;
        tick(6);
        chk1(INT_N_OE, 1'b0);
        chk1(INT_N_O, 1'b1);
        for (int i = 0; i < 4; i++) begin
            mute_drv = (i == 1) ? 1'b1 : 1'($urandom);
            tick(6);
            chk1(RX_LOSS_MUTE, mute_drv);
        end
        wr(7'h02, ~mreg[2], 16, 0);
        HOST_MODE = 1'b1;
        mute_drv = 1'b0;
        tick(8);
        chk1(RX_LOSS_MUTE, 1'b0);
        rdc(7'h02);
        $display("test 4 done");
        wr(7'h05, 8'hA5, 16, 1);
        NRST = 1'b0;
        #5;
        chk1(INT_N_OE, 1'b0);
        tick(2);
        NRST = 1'b1;
        mres();
        tick(10);
        chk1(INT_N_OE, 1'b1);
        rdc(7'h05);
        $display("test 5 done");
        close_out();
    end
endmodule : tb_top
